//--- pkg/soft_reset_pkg.sv
// Function
// - a write changes a reset bit only when its capability bit is set
// - bit 4 is the synchronous serial unit zero reset request, read/write, zero at reset
// - bits 16, 17, 18 are reset requests for timers 0, 1, 2, zero at reset
// - the reset-control register sits at offset 0x044, 32 bits, all zero at reset
`default_nettype none

package soft_reset_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int PERIPH_N = 6;

   // register byte addresses
   localparam logic [ADDR_W-1:0] SOFTWARE_RESET_CONTROL_ONE_OFFSET = 12'h044;
   localparam logic [ADDR_W-1:0] CAPABILITY_MASK_TWO_OFFSET = 12'h014;
   localparam logic [ADDR_W-1:0] RESET_WRITE_STATUS_OFFSET = 12'h0F0;

   // field positions inside the reset-control word
   localparam int ASYNC_SERIAL_ZERO_BIT = 0;
   localparam int SERIAL_SYNC_ZERO_BIT = 4;
   localparam int TIMER_ZERO_BIT = 16;
   localparam int TIMER_ONE_BIT = 17;
   localparam int TIMER_TWO_BIT = 18;
   localparam int COMPARATOR_ZERO_BIT = 24;

   // status register fields
   localparam int STATUS_REJECT_FLAG_BIT = 31;

   // values after reset
   localparam logic [DATA_W-1:0] SOFTWARE_RESET_CONTROL_ONE_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] RESET_WRITE_STATUS_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] READ_DATA_RESET = 32'h0000_0000;

   // edges after reset release before the capability strap is latched
   localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

   typedef int unsigned periph_pos_t [PERIPH_N];
   localparam periph_pos_t PERIPH_POS = '{
      ASYNC_SERIAL_ZERO_BIT, SERIAL_SYNC_ZERO_BIT, TIMER_ZERO_BIT,
      TIMER_ONE_BIT, TIMER_TWO_BIT, COMPARATOR_ZERO_BIT};

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic comparator_zero_reset;
      logic timer_two_reset;
      logic timer_one_reset;
      logic timer_zero_reset;
      logic serial_sync_zero_reset;
      logic async_serial_zero_reset;
   } periph_resets_s;

endpackage

`default_nettype wire

//--- hdl/reset_request_cell.sv
`timescale 1ns/1ps
`default_nettype none

module reset_request_cell
(
   input wire logic clk,
   input wire logic srst,
   input wire logic write_hit,
   input wire logic write_value,
   input wire logic present,
   output logic request
);
   import soft_reset_pkg::*;

   typedef struct packed {
      logic request;
   } cell_state_s;

   cell_state_s state;
   cell_state_s next_state;

   always_comb
   begin
      next_state = state;
      // absent peripherals keep their bit at zero whatever is written
      if (write_hit && present)
      begin
         next_state.request = write_value;
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign request = state.request;

endmodule // reset_request_cell

`default_nettype wire

//--- hdl/soft_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module soft_reset_ctrl
(
   input wire logic clk,
   input wire logic srst,
   input wire soft_reset_pkg::reg_req_s bus_req,
   output var logic [soft_reset_pkg::DATA_W-1:0] read_data,
   input wire logic [soft_reset_pkg::DATA_W-1:0] capability_strap,
   output var soft_reset_pkg::periph_resets_s periph_resets
);
   import soft_reset_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] strap_meta;
      logic [DATA_W-1:0] strap_sync;
      logic [1:0] settle_count;
      logic strap_latched;
      logic [PERIPH_N-1:0] present;
      logic [DATA_W-1:0] capability;
      logic reject_flag;
      logic [DATA_W-1:0] reject_bits;
      logic [DATA_W-1:0] read_data;
   } ctrl_state_s;

   ctrl_state_s state;
   ctrl_state_s next_state;

   logic [PERIPH_N-1:0] cell_request;
   logic [DATA_W-1:0] control_word;
   logic [DATA_W-1:0] implemented_mask;
   logic [DATA_W-1:0] present_mask;
   logic control_write;
   logic status_write;
   logic [DATA_W-1:0] reject_now;

   // each implemented bit is one cell; reserved bits have no storage
   genvar gi;
   generate
      for (gi = 0; gi < PERIPH_N; gi = gi + 1)
      begin : g_cell
         reset_request_cell u_cell
         (
            .clk(clk),
            .srst(srst),
            .write_hit(control_write),
            .write_value(bus_req.wdata[PERIPH_POS[gi]]),
            .present(state.present[gi]),
            .request(cell_request[gi])
         );
      end
   endgenerate

   // decode and word assembly
   always_comb
   begin
      control_word = SOFTWARE_RESET_CONTROL_ONE_RESET;
      implemented_mask = '0;
      present_mask = '0;
      for (int i = 0; i < PERIPH_N; i++)
      begin
         // reserved positions stay zero on read
         control_word[PERIPH_POS[i]] = cell_request[i];
         implemented_mask[PERIPH_POS[i]] = 1'b1;
         present_mask[PERIPH_POS[i]] = state.present[i];
      end
      control_write = bus_req.wr && (bus_req.addr == SOFTWARE_RESET_CONTROL_ONE_OFFSET);
      status_write = bus_req.wr && (bus_req.addr == RESET_WRITE_STATUS_OFFSET);
      // only attempts to raise a reset of an absent peripheral are recorded
      if (control_write)
      begin
         reject_now = bus_req.wdata & implemented_mask & ~present_mask;
      end
      else
      begin
         reject_now = '0;
      end
   end

   always_comb
   begin
      next_state = state;

      // strap crosses in from pins: second stage alone is read
      next_state.strap_meta = capability_strap;
      next_state.strap_sync = state.strap_meta;

      // strap is caught once after release, never during reset
      if (!state.strap_latched)
      begin
         if (state.settle_count == STRAP_SETTLE_CYCLES)
         begin
            next_state.strap_latched = 1'b1;
            next_state.capability = state.strap_sync & implemented_mask;
            for (int i = 0; i < PERIPH_N; i++)
            begin
               next_state.present[i] = state.strap_sync[PERIPH_POS[i]];
            end
         end
         else
         begin
            next_state.settle_count = state.settle_count + 2'h1;
         end
      end

      // write-one-to-clear, a new rejection in the same cycle wins
      if (status_write)
      begin
         if (bus_req.wdata[STATUS_REJECT_FLAG_BIT])
         begin
            next_state.reject_flag = 1'b0;
         end
         next_state.reject_bits = state.reject_bits & ~bus_req.wdata;
      end
      if (reject_now != '0)
      begin
         next_state.reject_flag = 1'b1;
      end
      next_state.reject_bits = next_state.reject_bits | reject_now;

      // read data stands only in the cycle after the strobe
      next_state.read_data = READ_DATA_RESET;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            SOFTWARE_RESET_CONTROL_ONE_OFFSET:
            begin
               next_state.read_data = control_word;
            end
            CAPABILITY_MASK_TWO_OFFSET:
            begin
               next_state.read_data = state.capability;
            end
            RESET_WRITE_STATUS_OFFSET:
            begin
               next_state.read_data = state.reject_bits;
               next_state.read_data[STATUS_REJECT_FLAG_BIT] = state.reject_flag;
            end
            default:
            begin
               // unmapped addresses answer zero, never stall
               next_state.read_data = READ_DATA_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state.strap_meta <= '0;
         state.strap_sync <= '0;
         state.settle_count <= '0;
         state.strap_latched <= 1'b0;
         // nothing is present until the strap is latched
         state.present <= '0;
         state.capability <= '0;
         state.reject_flag <= 1'b0;
         state.reject_bits <= RESET_WRITE_STATUS_RESET;
         state.read_data <= READ_DATA_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign read_data = state.read_data;

   // outputs come straight from the cell flops
   always_comb
   begin
      periph_resets.async_serial_zero_reset = cell_request[0];
      periph_resets.serial_sync_zero_reset = cell_request[1];
      periph_resets.timer_zero_reset = cell_request[2];
      periph_resets.timer_one_reset = cell_request[3];
      periph_resets.timer_two_reset = cell_request[4];
      periph_resets.comparator_zero_reset = cell_request[5];
   end

endmodule // soft_reset_ctrl

`default_nettype wire

//--- testbench/soft_reset_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none

module soft_reset_ctrl_properties
   import soft_reset_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire soft_reset_pkg::reg_req_s bus_req,
   input wire logic [soft_reset_pkg::DATA_W-1:0] read_data,
   input wire logic [soft_reset_pkg::DATA_W-1:0] capability_strap,
   input wire soft_reset_pkg::periph_resets_s periph_resets
);
   // edges since release; writes before the strap latch are ignored
   logic [2:0] age;
   logic hit;
   logic [5:0] present;

   always_ff @(posedge clk)
   begin
      if (srst)
         age <= 3'h0;
      else if (age != 3'h7)
         age <= age + 3'h1;
   end

   assign hit = bus_req.wr && bus_req.addr == SOFTWARE_RESET_CONTROL_ONE_OFFSET && age >= 3'h3;
   assign present = {capability_strap[24], capability_strap[18], capability_strap[17],
      capability_strap[16], capability_strap[4], capability_strap[0]};

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_RESET_CLEARS: assert property (disable iff (1'b0) srst |=> periph_resets == '0)
      else $error("outputs not cleared by reset");
   AST_ABSENT_NEVER_SET: assert property ((periph_resets & ~present) == 6'h00)
      else $error("reset raised for an absent peripheral");
   AST_SERIAL_WRITE: assert property (hit |=>
      periph_resets.serial_sync_zero_reset == ($past(bus_req.wdata[4]) & present[1]))
      else $error("serial reset bit does not follow write");
   AST_TIMER_WRITE: assert property (hit |=>
      periph_resets.timer_two_reset == ($past(bus_req.wdata[18]) & present[4]))
      else $error("timer two reset bit does not follow write");
   AST_COMPARATOR_WRITE: assert property (hit |=>
      periph_resets.comparator_zero_reset == ($past(bus_req.wdata[24]) & present[5]))
      else $error("comparator reset bit does not follow write");
   AST_HOLD: assert property (!bus_req.wr |=> $stable(periph_resets))
      else $error("reset outputs changed without a write");
   AST_READ_IDLE: assert property (!bus_req.rd |=> read_data == '0)
      else $error("read data not zero outside read answer");
   AST_READ_BACK: assert property (bus_req.rd && bus_req.addr == SOFTWARE_RESET_CONTROL_ONE_OFFSET
      |=> read_data == {7'h00, periph_resets[5], 5'h00, periph_resets[4:2], 11'h000,
      periph_resets[1], 3'h0, periph_resets[0]})
      else $error("reset control readback mismatch");

   COV_WRITE: cover property (hit && bus_req.wdata[16]);
   COV_READ: cover property (bus_req.rd && bus_req.addr == SOFTWARE_RESET_CONTROL_ONE_OFFSET);
   COV_HELD: cover property (periph_resets.comparator_zero_reset);
endmodule // soft_reset_ctrl_properties

bind soft_reset_ctrl soft_reset_ctrl_properties soft_reset_ctrl_properties_i (.clk(clk),
   .srst(srst), .bus_req(bus_req), .read_data(read_data),
   .capability_strap(capability_strap), .periph_resets(periph_resets));

`default_nettype wire

//--- testbench/tb_soft_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module tb_soft_reset_ctrl;
   import soft_reset_pkg::*;
   // timer one absent first, comparator absent after the second reset
   localparam logic [DATA_W-1:0] STRAP_FIRST = 32'hFFFD_FFFF;
   localparam logic [DATA_W-1:0] STRAP_SECOND = 32'hFEFF_FFFF;
   logic [DATA_W-1:0] strap = STRAP_FIRST;
   logic [DATA_W-1:0] word;
   localparam logic [ADDR_W-1:0] CTRL = SOFTWARE_RESET_CONTROL_ONE_OFFSET;
   logic clk = 1'b0;
   logic srst = 1'b1;
   reg_req_s req = '0;
   logic [DATA_W-1:0] read_data;
   periph_resets_s periph_resets;
   int errors = 0;
   int checks = 0;

   soft_reset_ctrl soft_reset_ctrl_i (.clk(clk), .srst(srst), .bus_req(req),
      .read_data(read_data), .capability_strap(strap), .periph_resets(periph_resets));

   initial forever #4 clk = ~clk;

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 chk(read_data, exp);
   endtask

   task automatic rdv(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 d = read_data;
   endtask

   task automatic outs(input logic [5:0] exp);
      chk({26'h0, periph_resets}, {26'h0, exp});
   endtask

   task automatic reset_dut(input logic [DATA_W-1:0] s);
      @(posedge clk);
      // strap only moves while reset holds, so the latch sees it settled
      srst <= 1'b1;
      strap <= s;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      // strap latch needs several edges before writes count
      repeat (5) @(posedge clk);
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   initial
   begin
      #20000;
      errors++;
      final_report();
   end

   initial
   begin
      reset_dut(STRAP_FIRST);
      rdc(CTRL, 32'h0000_0000);
      outs(6'h00);
      $display("test reset values done");
      wr(CTRL, 32'hFFFF_FFFF);
      rdc(CTRL, 32'h0105_0011);
      outs(6'h37);
      rdc(CAPABILITY_MASK_TWO_OFFSET, 32'h0105_0011);
      $display("test capability gate done");
      wr(CTRL, 32'h0000_0010);
      rdc(CTRL, 32'h0000_0010);
      outs(6'h02);
      wr(CTRL, 32'h0007_0000);
      rdc(CTRL, 32'h0005_0000);
      outs(6'h14);
      wr(CTRL, 32'h0100_0001);
      rdc(CTRL, 32'h0100_0001);
      outs(6'h21);
      $display("test field map done");
      rdc(RESET_WRITE_STATUS_OFFSET, 32'h8002_0000);
      wr(RESET_WRITE_STATUS_OFFSET, 32'h8000_0000);
      rdc(RESET_WRITE_STATUS_OFFSET, 32'h0002_0000);
      wr(RESET_WRITE_STATUS_OFFSET, 32'h0002_0000);
      rdc(RESET_WRITE_STATUS_OFFSET, 32'h0000_0000);
      $display("test reject status done");
      wr(12'h048, 32'hFFFF_FFFF);
      rdc(CTRL, 32'h0100_0001);
      rdc(12'h100, 32'h0000_0000);
      $display("test decode done");
      reset_dut(STRAP_SECOND);
      rdc(CTRL, 32'h0000_0000);
      outs(6'h00);
      $display("test second reset done");
      wr(CTRL, 32'h0100_0011);
      rdc(CTRL, 32'h0000_0011);
      rdv(CTRL, word);
      wr(CTRL, word | 32'h0002_0000);
      rdc(CTRL, 32'h0002_0011);
      outs(6'h0B);
      rdc(CAPABILITY_MASK_TWO_OFFSET, 32'h0007_0011);
      rdc(RESET_WRITE_STATUS_OFFSET, 32'h8100_0000);
      $display("test second strap done");
      final_report();
   end
endmodule // tb_soft_reset_ctrl

`default_nettype wire
